// >>> rtl/aicf_consts.svh
// Constants for the analog channel configuration and formatting block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef AICF_CONSTS_SVH
`define AICF_CONSTS_SVH

// Setup word field positions
`define AICF_EN_BIT 0
`define AICF_RNG_LSB 1
`define AICF_RNG_MSB 3
`define AICF_FMT_LSB 4
`define AICF_FMT_MSB 6
`define AICF_OC_LSB 7
`define AICF_OC_MSB 8
`define AICF_FILT_LSB 9
`define AICF_FILT_MSB 10
`define AICF_CAL_BIT 11
`define AICF_RSV_LSB 12
`define AICF_RSV_MSB 15
`define AICF_CFG_MSB 11

// Status word error bits
`define AICF_ST_OVR_BIT 12
`define AICF_ST_UND_BIT 13
`define AICF_ST_ERR_BIT 14
`define AICF_ST_FATAL_BIT 15

// Range codes, format codes, open-circuit codes
`define AICF_RNG_BIP10 3'h0
`define AICF_RNG_1TO5V 3'h1
`define AICF_RNG_0TO5V 3'h2
`define AICF_RNG_0TO10V 3'h3
`define AICF_RNG_0TO20MA 3'h4
`define AICF_RNG_4TO20MA 3'h5
`define AICF_FMT_ENG 3'h0
`define AICF_FMT_PID 3'h1
`define AICF_FMT_PROP 3'h2
`define AICF_FMT_LEGACY 3'h3
`define AICF_FMT_USER_A 3'h4
`define AICF_FMT_USER_B 3'h5
`define AICF_OC_ZERO 2'h0
`define AICF_OC_MAX 2'h1
`define AICF_OC_MIN 2'h2
`define AICF_OC_BAD 2'h3

// Signal and count limits, one count per mV or per uA
`define AICF_V_10250 18'sh0280a
`define AICF_V_10000 18'sh02710
`define AICF_V_5500 18'sh0157c
`define AICF_V_5000 18'sh01388
`define AICF_V_1000 18'sh003e8
`define AICF_V_500 18'sh001f4
`define AICF_V_ZERO 18'sh00000
`define AICF_I_20500 18'sh05014
`define AICF_I_20000 18'sh04e20
`define AICF_I_4000 18'sh00fa0
`define AICF_I_3500 18'sh00dac
`define AICF_C_16383 18'sh03fff
`define AICF_C_16384 18'sh04000
`define AICF_C_3277 18'sh00ccd
`define AICF_C_32767 18'sh07fff
`define AICF_C_32768 18'sh08000

// Auto-calibration repeat time and clock rate
`define AICF_CAL_PERIOD_S 10
`define AICF_CLK_HZ 10000000

`endif

// >>> rtl/aicf_pkg.sv
// Types shared by the channel formatter and the channel control top.
// Assumes aicf_consts.svh is on the include path.
`include "aicf_consts.svh"

package aicf_pkg;

    typedef logic [15:0] aicf_word_t;
    typedef logic signed [17:0] aicf_val_t;

    // Decoded channel configuration, bits 1 to 11 of the setup word
    typedef struct packed {
        logic autocal;
        logic [1:0] filt;
        logic [1:0] oc;
        logic [2:0] fmt;
        logic [2:0] rng;
    } aicf_cfg_t;

    // A pair of low and high limits
    typedef struct packed {
        aicf_val_t lo;
        aicf_val_t hi;
    } aicf_lim_t;

    // Channel sequence, Gray coded along off, calibrate, run
    typedef enum logic [1:0] {
        AICF_OFF = 2'h0,
        AICF_CAL = 2'h1,
        AICF_RUN = 2'h3,
        AICF_ERR = 2'h2
    } aicf_state_t;

endpackage : aicf_pkg

// >>> rtl/aicf_fmt.sv
// Combinational formatter: one engineering-unit sample to format counts.
// Assumes the caller registers the result and holds the inputs stable.
`include "aicf_consts.svh"

module aicf_fmt (
    input wire aicf_pkg::aicf_cfg_t cfg_in,
    input wire aicf_pkg::aicf_lim_t user_lim_in,
    input wire logic signed [15:0] sample_in,
    input wire logic open_in,
    output logic [15:0] value_out,
    output logic over_out,
    output logic under_out
);
    import aicf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Limit tables

    // Extended signal span per range
    function automatic aicf_lim_t ext_lim(input logic [2:0] rng);
        case (rng)
            `AICF_RNG_BIP10: ext_lim = '{-`AICF_V_10250, `AICF_V_10250};
            `AICF_RNG_1TO5V: ext_lim = '{`AICF_V_500, `AICF_V_5500};
            `AICF_RNG_0TO5V: ext_lim = '{-`AICF_V_500, `AICF_V_5500};
            `AICF_RNG_0TO10V: ext_lim = '{-`AICF_V_500, `AICF_V_10250};
            `AICF_RNG_0TO20MA: ext_lim = '{`AICF_V_ZERO, `AICF_I_20500};
            default: ext_lim = '{`AICF_I_3500, `AICF_I_20500};
        endcase
    endfunction

    // Nominal signal span per range
    function automatic aicf_lim_t nom_lim(input logic [2:0] rng);
        case (rng)
            `AICF_RNG_BIP10: nom_lim = '{-`AICF_V_10000, `AICF_V_10000};
            `AICF_RNG_1TO5V: nom_lim = '{`AICF_V_1000, `AICF_V_5000};
            `AICF_RNG_0TO5V: nom_lim = '{`AICF_V_ZERO, `AICF_V_5000};
            `AICF_RNG_0TO10V: nom_lim = '{`AICF_V_ZERO, `AICF_V_10000};
            `AICF_RNG_0TO20MA: nom_lim = '{`AICF_V_ZERO, `AICF_I_20000};
            default: nom_lim = '{`AICF_I_4000, `AICF_I_20000};
        endcase
    endfunction

    // Legacy-compatible count limits per range
    function automatic aicf_lim_t leg_lim(input logic [2:0] rng);
        case (rng)
            `AICF_RNG_BIP10: leg_lim = '{-`AICF_C_32768, `AICF_C_32767};
            `AICF_RNG_0TO10V: leg_lim = '{`AICF_V_ZERO, `AICF_C_32767};
            `AICF_RNG_1TO5V,
            `AICF_RNG_4TO20MA: leg_lim = '{`AICF_C_3277, `AICF_C_16384};
            default: leg_lim = '{`AICF_V_ZERO, `AICF_C_16384};
        endcase
    endfunction

    // Clamp into [lo, hi], whichever order the pair arrives in
    function automatic logic signed [39:0] sat(
        input logic signed [39:0] v,
        input aicf_val_t a,
        input aicf_val_t b
    );
        logic signed [39:0] lo;
        logic signed [39:0] hi;
        lo = (a < b) ? 40'(a) : 40'(b);
        hi = (a < b) ? 40'(b) : 40'(a);
        if (v < lo) begin
            sat = lo;
        end else if (v > hi) begin
            sat = hi;
        end else begin
            sat = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scaling

    aicf_lim_t sig_lim;
    aicf_lim_t cnt_lim;
    logic signed [39:0] s_clip;
    logic signed [39:0] prod;
    logic signed [39:0] scaled;
    logic signed [39:0] final_v;
    logic oc_applies;

    // format spans
    // Pick signal span and count span from format and range
    always_comb begin
        sig_lim = ext_lim(cfg_in.rng);
        cnt_lim = ext_lim(cfg_in.rng);
        case (cfg_in.fmt)
            `AICF_FMT_PID: begin
                sig_lim = nom_lim(cfg_in.rng);
                cnt_lim = '{`AICF_V_ZERO, `AICF_C_16383};
            end
            `AICF_FMT_PROP: begin
                cnt_lim = '{-`AICF_C_32768, `AICF_C_32767};
            end
            `AICF_FMT_LEGACY: begin
                sig_lim = nom_lim(cfg_in.rng);
                cnt_lim = leg_lim(cfg_in.rng);
            end
            `AICF_FMT_USER_A,
            `AICF_FMT_USER_B: begin
                cnt_lim = user_lim_in;
            end
            default: begin
                cnt_lim = ext_lim(cfg_in.rng);
            end
        endcase
    end

    // Linear map; signal spans are never zero, so the divide is safe.
    // A user pair given with high below low scales with a negative slope.
    always_comb begin
        s_clip = sat(40'(sample_in), sig_lim.lo, sig_lim.hi);
        prod = (s_clip - 40'(sig_lim.lo)) * (40'(cnt_lim.hi) -
            40'(cnt_lim.lo));
        scaled = 40'(cnt_lim.lo) + prod / (40'(sig_lim.hi) -
            40'(sig_lim.lo));
        final_v = sat(scaled, cnt_lim.lo, cnt_lim.hi);
    end

    // Open-circuit substitution only for live-zero ranges
    assign oc_applies = (cfg_in.rng == `AICF_RNG_1TO5V) ||
        (cfg_in.rng == `AICF_RNG_4TO20MA);

    always_comb begin
        value_out = final_v[15:0];
        if (open_in && oc_applies) begin
            case (cfg_in.oc)
                `AICF_OC_MAX: value_out = cnt_lim.hi[15:0];
                `AICF_OC_MIN: value_out = cnt_lim.lo[15:0];
                default: value_out = 16'h0000;
            endcase
        end
    end

    // Range flags at or beyond the signal span edges
    assign over_out = 40'(sample_in) >= 40'(sig_lim.hi);
    assign under_out = 40'(sample_in) <= 40'(sig_lim.lo);

endmodule : aicf_fmt

// >>> rtl/aicf_top.sv
// Channel configuration decoder and result formatter, NCH channels.
// Assumes the host image words and the converter inputs share clock_in.
//
// Functional notes
// - Range code for each channel comes from setup bits 1 to 3.
// - Data format comes from setup bits 4 to 6, six formats.
// - Engineering format reports mV or uA counts within extended limits.
// - PID format maps nominal span onto 0 to 16383, no over-range.
// - Proportional format maps extended span onto -32768 to 32767.
// - Legacy format uses its own per-range count limits.
// - Scale A limits from words 4 and 5, scale B from 6 and 7.
// - First word of a pair is the signed low limit, second the high.
// - New scale limits apply only after the enable bit is toggled.
// - User scale value is a linear map of the extended signal span.
// - Open-circuit response applies only to 1-5 V and 4-20 mA.
// - Zero response forces the data word to zero while open.
// - Max or min response forces the active count limit while open.
// - Converted values are delivered until the open is flagged.
// - Filter select from bits 9 and 10 goes to the converter.
// - Auto-calibration bit set repeats calibration every ten seconds.
// - Every valid configuration also runs one calibration.
// - Nonzero setup bits 12 to 15 make a configuration error.
// - Results appear in words 0 to 3; disabled channels read zero.
// - Setup is latched on enable rising; data and status zero while off.
// - Format codes 110 and 111 are invalid.
// - Invalid setup sets status bit 14 until the enable bit is cleared.
`include "aicf_consts.svh"

module aicf_top #(
    parameter int NCH = 4,
    parameter int CAL_CNT_W = 27,
    parameter int CAL_PERIOD_CYCLES = `AICF_CAL_PERIOD_S * `AICF_CLK_HZ
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire aicf_pkg::aicf_word_t [NCH-1:0] setup_word_in,
    input wire aicf_pkg::aicf_word_t scale_a_low_limit_in,
    input wire aicf_pkg::aicf_word_t scale_a_high_limit_in,
    input wire aicf_pkg::aicf_word_t scale_b_low_limit_in,
    input wire aicf_pkg::aicf_word_t scale_b_high_limit_in,
    input wire aicf_pkg::aicf_word_t [NCH-1:0] sample_in,
    input wire logic [NCH-1:0] sample_valid_in,
    input wire logic [NCH-1:0] open_in,
    input wire logic [NCH-1:0] cal_done_in,
    output aicf_pkg::aicf_word_t [NCH-1:0] channel_result_word_out,
    output aicf_pkg::aicf_word_t [NCH-1:0] status_word_out,
    output logic [NCH-1:0][1:0] filter_sel_out,
    output logic [NCH-1:0] cal_req_out
);
    import aicf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Shared calibration timebase

    logic [CAL_CNT_W-1:0] cal_cnt_ff;
    logic cal_tick_ff;

    // One-cycle tick every calibration period, shared by all channels
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cal_cnt_ff <= '0;
            cal_tick_ff <= 1'b0;
        end else if (cal_cnt_ff ==
                CAL_CNT_W'(CAL_PERIOD_CYCLES - 1)) begin
            cal_cnt_ff <= '0;
            cal_tick_ff <= 1'b1;
        end else begin
            cal_cnt_ff <= cal_cnt_ff + CAL_CNT_W'(1);
            cal_tick_ff <= 1'b0;
        end
    end

    // Setup word check shared by all channels
    function automatic logic setup_ok(input aicf_word_t w);
        setup_ok = (w[`AICF_RNG_MSB:`AICF_RNG_LSB] <=
                `AICF_RNG_4TO20MA) &&
            (w[`AICF_FMT_MSB:`AICF_FMT_LSB] <= `AICF_FMT_USER_B) &&
            (w[`AICF_OC_MSB:`AICF_OC_LSB] != `AICF_OC_BAD) &&
            (w[`AICF_RSV_MSB:`AICF_RSV_LSB] == 4'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-channel control

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        aicf_state_t st_ff;
        logic en_prev_ff;
        aicf_cfg_t cfg_ff;
        aicf_lim_t lim_a_ff;
        aicf_lim_t lim_b_ff;
        logic signed [15:0] sample_ff;
        logic have_sample_ff;
        aicf_word_t result_ff;
        aicf_word_t status_ff;
        logic cal_req_ff;
        logic en;
        logic en_rise;
        aicf_lim_t user_lim;
        logic [15:0] fmt_val;
        logic fmt_over;
        logic fmt_under;

        assign en = setup_word_in[ch][`AICF_EN_BIT];
        assign en_rise = en && !en_prev_ff;

        // Enable edge detector
        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                en_prev_ff <= 1'b0;
            end else begin
                en_prev_ff <= en;
            end
        end

        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                cfg_ff <= '0;
            end else if (en_rise) begin
                cfg_ff <= setup_word_in[ch][`AICF_CFG_MSB:`AICF_RNG_LSB];
            end
        end

        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                lim_a_ff <= '0;
                lim_b_ff <= '0;
            end else if (en_rise) begin
                lim_a_ff <= '{18'(signed'(scale_a_low_limit_in)),
                    18'(signed'(scale_a_high_limit_in))};
                lim_b_ff <= '{18'(signed'(scale_b_low_limit_in)),
                    18'(signed'(scale_b_high_limit_in))};
            end
        end

        // sequence
        // Hangs in calibrate until the converter acknowledges it.
        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                st_ff <= AICF_OFF;
            end else if (!en) begin
                st_ff <= AICF_OFF;
            end else if (en_rise) begin
                st_ff <= setup_ok(setup_word_in[ch]) ? AICF_CAL : AICF_ERR;
            end else begin
                case (st_ff)
                    AICF_CAL: st_ff <= cal_done_in[ch] ? AICF_RUN : AICF_CAL;
                    AICF_RUN: st_ff <= AICF_RUN;
                    AICF_ERR: st_ff <= AICF_ERR;
                    default: st_ff <= AICF_OFF;
                endcase
            end
        end

        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                cal_req_ff <= 1'b0;
            end else begin
                cal_req_ff <= (en && en_rise && setup_ok(setup_word_in[ch]))
                    || (en && !en_rise && st_ff == AICF_RUN &&
                    cfg_ff.autocal && cal_tick_ff);
            end
        end

        // Last converted sample; dropped when the channel goes off
        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                sample_ff <= '0;
                have_sample_ff <= 1'b0;
            end else if (st_ff != AICF_RUN) begin
                have_sample_ff <= 1'b0;
            end else if (sample_valid_in[ch]) begin
                sample_ff <= signed'(sample_in[ch]);
                have_sample_ff <= 1'b1;
            end
        end

        assign user_lim = (cfg_ff.fmt == `AICF_FMT_USER_B) ? lim_b_ff :
            lim_a_ff;

        aicf_fmt u_fmt (
            .cfg_in(cfg_ff),
            .user_lim_in(user_lim),
            .sample_in(sample_ff),
            .open_in(open_in[ch]),
            .value_out(fmt_val),
            .over_out(fmt_over),
            .under_out(fmt_under)
        );

        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                result_ff <= '0;
            end else if (st_ff == AICF_RUN && en && have_sample_ff) begin
                result_ff <= fmt_val;
            end else begin
                result_ff <= '0;
            end
        end

        always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
                status_ff <= '0;
            end else if (!en || en_rise) begin
                status_ff <= '0;
            end else begin
                case (st_ff)
                    AICF_RUN: begin
                        status_ff <= {1'b0, 1'b0,
                            fmt_under && have_sample_ff,
                            fmt_over && have_sample_ff, cfg_ff, 1'b1};
                    end
                    AICF_ERR: begin
                        status_ff <= {1'b0, 1'b1, 2'h0, cfg_ff, 1'b1};
                    end
                    default: begin
                        status_ff <= '0;
                    end
                endcase
            end
        end

        assign channel_result_word_out[ch] = result_ff;
        assign status_word_out[ch] = status_ff;
        assign filter_sel_out[ch] = cfg_ff.filt;
        assign cal_req_out[ch] = cal_req_ff;
    end

endmodule : aicf_top

// >>> tb/aicf_monitor.sv
// Checker for the channel control top, watching channel 0.
// Assumes bind into aicf_top; inputs change away from the rising edge.
module aicf_monitor #(
    parameter int NCH = 4
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire aicf_pkg::aicf_word_t [NCH-1:0] setup_word_in,
    input wire logic [NCH-1:0] open_in,
    input wire aicf_pkg::aicf_word_t [NCH-1:0] channel_result_word_out,
    input wire aicf_pkg::aicf_word_t [NCH-1:0] status_word_out,
    input wire logic [NCH-1:0][1:0] filter_sel_out,
    input wire logic [NCH-1:0] cal_req_out
);
    import aicf_pkg::*;

    logic [15:0] sw0;
    logic [15:0] st0;
    logic [15:0] d0;
    logic ok0;

    // Channel 0 views; ok0 mirrors which setup words are legal
    assign sw0 = setup_word_in[0];
    assign st0 = status_word_out[0];
    assign d0 = channel_result_word_out[0];
    assign ok0 = sw0[3:1] < 3'h6 && sw0[6:4] < 3'h6 && sw0[8:7] != 2'h3
        && sw0[15:12] == 4'h0;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    ////////////////////////////////////////
    a_cal_on_cfg: assert property (
        $rose(sw0[0]) && ok0 |=> cal_req_out[0])
        else $error("no calibration after setup");
    a_bad_cfg_flag: assert property (
        $rose(sw0[0]) && !ok0 |=> !cal_req_out[0] ##1 st0[14])
        else $error("bad setup not flagged");
    // Two low edges so a late status update is not blamed
    a_off_zero: assert property (
        !sw0[0] ##1 !sw0[0] |=> d0 == 16'h0000 && st0 == 16'h0000)
        else $error("disabled channel not zero");
    a_filt_latch: assert property (
        $rose(sw0[0]) && ok0 |=> filter_sel_out[0] == $past(sw0[10:9]))
        else $error("filter code not latched");
    a_cfg_held: assert property (
        st0[0] && $past(st0[0]) |-> st0[11:0] == $past(st0[11:0]))
        else $error("config changed without toggle");
    a_pid_limit: assert property (
        st0[0] && st0[6:4] == 3'h1 |-> d0 <= 16'h3fff)
        else $error("pid count above span");
    a_eng_limit: assert property (
        st0[0] && st0[6:1] == 6'h00
        |-> $signed(d0) >= -10250 && $signed(d0) <= 10250)
        else $error("engineering count outside limits");
    a_legacy_top: assert property (
        st0[0] && st0[6:4] == 3'h3 && st0[3:1] inside {3'h1, 3'h2, 3'h4,
        3'h5} |-> d0 <= 16'h4000)
        else $error("legacy count above limit");
    a_open_zero: assert property (
        st0[0] && st0[3:1] == 3'h1 && st0[8:7] == 2'h0 && open_in[0]
        |=> d0 == 16'h0000)
        else $error("open input not zeroed");
    a_no_autocal: assert property (
        st0[0] && !st0[11] && $past(sw0[0], 2) |-> !cal_req_out[0])
        else $error("calibration with autocal off");
endmodule // aicf_monitor

bind aicf_top aicf_monitor #(.NCH(NCH)) u_mon (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .setup_word_in(setup_word_in),
    .open_in(open_in),
    .channel_result_word_out(channel_result_word_out),
    .status_word_out(status_word_out),
    .filter_sel_out(filter_sel_out),
    .cal_req_out(cal_req_out)
);

// >>> tb/aicf_fe_model.sv
// Converter front-end model: answers calibration requests.
// Assumes requests are one-cycle pulses on the shared clock.
module aicf_fe_model #(
    parameter int NCH = 4
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [NCH-1:0] cal_req_in,
    output logic [NCH-1:0] cal_done_out
);
    logic [NCH-1:0][3:0] wait_ff;
    logic [NCH-1:0] busy_ff;

    // finish calibrations
    // Channel 0 answers the cycle after the request, each higher channel three cycles later
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_ff <= '0;
            wait_ff <= '0;
            cal_done_out <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                cal_done_out[i] <= 1'b0;
                if (cal_req_in[i]) begin
                    busy_ff[i] <= 1'b1;
                    wait_ff[i] <= 4'(3 * i);
                end else if (busy_ff[i] && wait_ff[i] == 4'h0) begin
                    busy_ff[i] <= 1'b0;
                    cal_done_out[i] <= 1'b1;
                end else if (busy_ff[i]) begin
                    wait_ff[i] <= wait_ff[i] - 4'h1;
                end
            end
        end
    end
endmodule // aicf_fe_model

// >>> tb/tb_top.sv
// Self-checking bench for the channel control top.
// Assumes the front-end model answers every calibration request.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import aicf_pkg::*;

    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    aicf_word_t [3:0] setup = '0;
    aicf_word_t [3:0] smpl = '0;
    aicf_word_t lo_a = '0;
    aicf_word_t hi_a = '0;
    aicf_word_t lo_b = '0;
    aicf_word_t hi_b = '0;
    logic [3:0] vld = '0;
    logic [3:0] opn = '0;
    logic [3:0] done;
    logic [3:0] creq;
    logic [3:0][1:0] filt;
    aicf_word_t [3:0] res;
    aicf_word_t [3:0] st;
    int num_errors = 0;
    int checks_done = 0;

    // 10 MHz clock
    always #50 clock_in = ~clock_in;

    // Short calibration period keeps the periodic case quick
    aicf_top #(.NCH(4), .CAL_PERIOD_CYCLES(50)) DUT (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .setup_word_in(setup),
        .scale_a_low_limit_in(lo_a),
        .scale_a_high_limit_in(hi_a),
        .scale_b_low_limit_in(lo_b),
        .scale_b_high_limit_in(hi_b),
        .sample_in(smpl),
        .sample_valid_in(vld),
        .open_in(opn),
        .cal_done_in(done),
        .channel_result_word_out(res),
        .status_word_out(st),
        .filter_sel_out(filt),
        .cal_req_out(creq)
    );
    aicf_fe_model #(.NCH(4)) u_fe (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .cal_req_in(creq),
        .cal_done_out(done)
    );

    ////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] sw(input logic [2:0] r, f,
        input logic [1:0] oc, fl, input logic ac);
        return {4'h0, ac, fl, oc, f, r, 1'b1};
    endfunction

    // Enable low for three edges, then high; wait for the echo
    task automatic cfg(input int ch, input logic [15:0] w);
        int n;
        int reqs;
        logic ok;
        ok = w[3:1] < 3'h6 && w[6:4] < 3'h6 && w[8:7] != 2'h3
            && w[15:12] == 4'h0;
        n = 0;
        reqs = 0;
        @(negedge clock_in);
        setup[ch] = w & 16'hfffe;
        repeat (3) @(negedge clock_in);
        setup[ch] = w;
        while (st[ch][0] !== 1'b1 && n < 60) begin
            @(negedge clock_in);
            // A periodic pulse on the echo edge is not the configure one
            reqs += int'(creq[ch] === 1'b1 && st[ch][0] !== 1'b1);
            n++;
        end
        if (n == 60) begin
            num_errors++;
            summarize();
        end
        chk(16'(reqs), {15'h0, ok});
        chk({st[ch][15:14], st[ch][11:0]}, {1'b0, ~ok, w[11:0]});
        if (ok) chk({14'h0, filt[ch]}, {14'h0, w[10:9]});
    endtask

    // One sample pulse; result read once it has settled
    task automatic smp(input int ch, input int v, input logic [15:0] exp);
        @(negedge clock_in);
        smpl[ch] = 16'(v);
        vld[ch] = 1'b1;
        @(negedge clock_in);
        vld[ch] = 1'b0;
        repeat (2) @(negedge clock_in);
        chk(res[ch], exp);
    endtask

    task automatic open_chk(input int ch, input logic [15:0] exp);
        @(negedge clock_in);
        opn[ch] = 1'b1;
        repeat (2) @(negedge clock_in);
        chk(res[ch], exp);
        opn[ch] = 1'b0;
        @(negedge clock_in);
    endtask

    ////////////////////////////////////////
    task automatic t_eng();
        cfg(0, sw(3'h0, 3'h0, 2'h0, 2'h1, 1'b0));
        smp(0, 1234, 16'h04d2);
        smp(0, -10250, 16'hd7f6);
        smp(0, 12000, 16'h280a);
        @(negedge clock_in);
        setup[0][0] = 1'b0;
        repeat (3) @(negedge clock_in);
        chk(res[0], 16'h0000);
        chk(st[0], 16'h0000);
        chk(res[1], 16'h0000);
    endtask

    task automatic t_pid_prop();
        cfg(0, sw(3'h3, 3'h1, 2'h0, 2'h2, 1'b0));
        smp(0, 10000, 16'h3fff);
        smp(0, 10250, 16'h3fff);
        smp(0, -500, 16'h0000);
        cfg(2, sw(3'h0, 3'h2, 2'h0, 2'h3, 1'b0));
        smp(2, -10250, 16'h8000);
        smp(2, 10250, 16'h7fff);
        smp(2, 30000, 16'h7fff);
    endtask

    task automatic t_legacy();
        int hs [6] = '{10000, 5000, 5000, 10000, 20000, 20000};
        int ls [6] = '{-10000, 1000, 0, 0, 0, 4000};
        logic [15:0] lc [6] = '{16'h8000, 16'h0ccd, 16'h0000, 16'h0000,
            16'h0000, 16'h0ccd};
        for (int r = 0; r < 6; r++) begin
            cfg(3, sw(3'(r), 3'h3, 2'h0, 2'h0, 1'b0));
            smp(3, hs[r], (r == 0 || r == 3) ? 16'h7fff : 16'h4000);
            smp(3, ls[r], lc[r]);
        end
    endtask

    task automatic t_user();
        lo_a = 16'h0064;
        hi_a = 16'h270f;
        hi_b = 16'h03e8;
        cfg(0, sw(3'h5, 3'h4, 2'h0, 2'h0, 1'b0));
        smp(0, 3500, 16'h0064);
        smp(0, 20500, 16'h270f);
        lo_a = 16'h8000;
        hi_a = 16'h7fff;
        smp(0, 20500, 16'h270f);
        cfg(0, sw(3'h4, 3'h5, 2'h0, 2'h0, 1'b0));
        smp(0, 10250, 16'h01f4);
        cfg(0, sw(3'h5, 3'h4, 2'h0, 2'h0, 1'b0));
        smp(0, 3500, 16'h8000);
        smp(0, 20500, 16'h7fff);
    endtask

    task automatic t_open();
        cfg(0, sw(3'h1, 3'h0, 2'h0, 2'h0, 1'b0));
        smp(0, 3000, 16'h0bb8);
        open_chk(0, 16'h0000);
        cfg(0, sw(3'h1, 3'h0, 2'h1, 2'h0, 1'b0));
        smp(0, 3000, 16'h0bb8);
        open_chk(0, 16'h157c);
        cfg(0, sw(3'h5, 3'h3, 2'h2, 2'h0, 1'b0));
        smp(0, 20000, 16'h4000);
        open_chk(0, 16'h0ccd);
        cfg(0, sw(3'h0, 3'h0, 2'h1, 2'h0, 1'b0));
        smp(0, 700, 16'h02bc);
        open_chk(0, 16'h02bc);
    endtask

    task automatic t_bad();
        logic [15:0] bad [7] = '{16'h000d, 16'h000f, 16'h0061, 16'h0071,
            16'h0181, 16'h1001, 16'h8001};
        for (int i = 0; i < 7; i++) cfg(0, bad[i]);
        cfg(0, sw(3'h2, 3'h2, 2'h0, 2'h0, 1'b0));
        smp(0, 5500, 16'h7fff);
    endtask

    // Any 100 cycles hold exactly two 50-cycle ticks
    task automatic t_cal();
        int n;
        for (int ac = 1; ac >= 0; ac--) begin
            cfg(3, sw(3'h0, 3'h0, 2'h0, 2'h3, 1'(ac)));
            n = 0;
            repeat (100) begin
                @(negedge clock_in);
                n += int'(creq[3] === 1'b1);
            end
            chk(16'(n), 16'(2 * ac));
        end
    endtask

    initial begin
        repeat (6) @(posedge clock_in);
        @(negedge clock_in);
        resetn_in = 1'b1;
        @(negedge clock_in);
        for (int i = 0; i < 4; i++) chk(res[i] | st[i], 16'h0000);
        t_eng();
        t_pid_prop();
        t_legacy();
        t_user();
        t_open();
        t_bad();
        t_cal();
        summarize();
    end
endmodule // tb_top
